// file: core/afd_top.sv
`timescale 1ns/1ps
// Functional notes
// - fabric logic runs from one fabric clock derived with the cpu clock.
// - pll lock low holds all fabric logic except the fifo memory in asynchronous reset.
// - a low level on the external reset input resets the fabric logic.
// - write-side irq reports fill threshold, almost full and full.
// - read-side irq reports drain threshold, almost empty and empty.
// - in cpu-writes mode the empty flag goes out on a gpio line.
// - the fabric reader waits for full, drains, checks each word.
// - pass and fail outputs are single bits and active low.
// - in fabric-writes mode the writer fills until full, then stops.
// - once full the fabric writer shows full on a gpio line.
// - write status 0x10 from 0x1f0, 0x14 at 0x1ff, 0x11 when full.
// - read status 0x20 from 8, 0x28 at 1, 0x22 at 0.
// - the fifo holds 512 words and the count wraps to zero when full.
module afd_top
  import afd_pkg::*;
#(
  parameter int          DEPTH      = DEF_DEPTH,
  parameter int          WIDTH      = DEF_WIDTH,
  parameter int          PFULL      = DEF_PFULL,
  parameter int          PEMPTY     = DEF_PEMPTY,
  parameter logic [31:0] PAT_BASE   = DEF_PAT_BASE
) (
  input  wire logic              CLK_SYS_IN,
  input  wire logic              RSTN_IN,
  input  wire logic              PLL_LOCK_IN,
  input  wire logic [REG_AW-1:0] ADDR_IN,
  input  wire logic [31:0]       WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [31:0]       RDATA_OUT,
  output logic                   IRQ_OUT,
  output logic                   GPIO_EMPTY_OUT,
  output logic                   GPIO_FULL_OUT,
  output logic                   RD_PASS_N_OUT,
  output logic                   RD_FAIL_N_OUT
);

  localparam int AW = $clog2(DEPTH);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if ((1 << AW) != DEPTH || DEPTH < 16)
    $error("DEPTH must be a power of two of at least 16");
  if (WIDTH != 32)
    $error("WIDTH must be 32 for the register port");
  if (PFULL >= DEPTH || PEMPTY < 2 || PEMPTY >= DEPTH)
    $error("thresholds out of range");

  typedef struct packed {
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [3:0]       ctrl;
    logic [FLG_W-1:0] irq_stat;
    logic [FLG_W-1:0] irq_mask;
    logic [FLG_W-1:0] flags;
    logic [31:0]      rdata;
    afd_state_t       state;
    logic [AW:0]      idx;
    logic             mism;
    logic             pass_n;
    logic             fail_n;
    logic             gpio_e;
    logic             gpio_f;
  } afd_regs_t;

  afd_regs_t         regs_ff;
  afd_regs_t         nxt_regs;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic [1:0]        rst_sync_ff;
  logic              rst_n;
  logic              full;
  logic              empty;
  logic              push;
  logic              pop;
  logic              push_ok;
  logic              pop_ok;
  logic [WIDTH-1:0]  push_data;
  logic [WIDTH-1:0]  head;
  logic [FLG_W-1:0]  flg_now;
  logic [1:0]        mode;
  logic              fab_push;
  logic              fab_pop;
  logic              bus_push;
  logic              bus_pop;

  function automatic logic [31:0] afd_pattern(input logic [AW:0] i);
    afd_pattern = PAT_BASE + {{(31-AW-2){1'b0}}, i, 2'b00};
  endfunction : afd_pattern

  // ************************************************************
  // reset
  // ************************************************************
  // lock and pin combine
  // release is synchronised so no flop sees a ragged deassert
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN or negedge PLL_LOCK_IN) begin
    if (!RSTN_IN || !PLL_LOCK_IN) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ************************************************************
  // fifo core
  // ************************************************************
  // depth and wrap
  assign full   = regs_ff.count[AW];
  assign empty  = (regs_ff.count == '0);
  assign mode   = regs_ff.ctrl[BIT_MODE_LO +: 2];
  assign head   = mem[regs_ff.rd_ptr];

  assign bus_push = WR_IN && (ADDR_IN == OFS_DATA);
  assign bus_pop  = RD_IN && (ADDR_IN == OFS_DATA);
  assign fab_push = (regs_ff.state == AFD_MOVE) && (mode == MODE_FAB_CPU);
  assign fab_pop  = (regs_ff.state == AFD_MOVE) && (mode == MODE_CPU_FAB);

  assign push      = (mode == MODE_FAB_CPU) ? fab_push : bus_push;
  assign pop       = (mode == MODE_CPU_FAB) ? fab_pop  : bus_pop;
  assign push_data = (mode == MODE_FAB_CPU) ? afd_pattern(regs_ff.idx)
                                            : WDATA_IN;
  assign push_ok   = push && !full;
  assign pop_ok    = pop && !empty;

  always_ff @(posedge CLK_SYS_IN) begin
    if (push_ok) begin
      mem[regs_ff.wr_ptr] <= push_data;
    end
  end

  always_comb begin
    flg_now             = '0;
    flg_now[BIT_FULL]   = full;
    flg_now[BIT_EMPTY]  = empty;
    flg_now[BIT_AFULL]  = (regs_ff.count == (AW+1)'(DEPTH - 1));
    flg_now[BIT_AEMPTY] = (regs_ff.count == (AW+1)'(1));
    flg_now[BIT_PFULL]  = (regs_ff.count >= (AW+1)'(PFULL));
    flg_now[BIT_PEMPTY] = (regs_ff.count <= (AW+1)'(PEMPTY));
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_regs       = regs_ff;
    nxt_regs.flags = flg_now;
    nxt_regs.rdata = 32'h0000_0000;

    if (push_ok) begin
      nxt_regs.wr_ptr = regs_ff.wr_ptr + 1'b1;
    end
    if (pop_ok) begin
      nxt_regs.rd_ptr = regs_ff.rd_ptr + 1'b1;
    end
    nxt_regs.count = regs_ff.count + (AW+1)'(push_ok) - (AW+1)'(pop_ok);

    // go self-clears; a fresh ctrl write below may set it again
    nxt_regs.ctrl[BIT_GO] = 1'b0;

    // register writes
    if (WR_IN && ADDR_IN == OFS_CTRL) begin
      nxt_regs.ctrl = WDATA_IN[3:0];
    end
    if (WR_IN && ADDR_IN == OFS_IRQ_MASK) begin
      nxt_regs.irq_mask = WDATA_IN[FLG_W-1:0];
    end

    // register reads, answered next cycle
    if (RD_IN) begin
      case (ADDR_IN)
        OFS_DATA: begin
          nxt_regs.rdata = empty ? 32'h0000_0000 : head;
        end
        OFS_STAT_W: begin
          nxt_regs.rdata = {26'h0, flg_now & WR_SIDE_BITS};
        end
        OFS_STAT_R: begin
          nxt_regs.rdata = {26'h0, flg_now & RD_SIDE_BITS};
        end
        OFS_WRCNT: begin
          nxt_regs.rdata = {{(32-AW){1'b0}}, regs_ff.count[AW-1:0]};
        end
        OFS_RDCNT: begin
          nxt_regs.rdata = {{(32-AW){1'b0}}, regs_ff.count[AW-1:0]};
        end
        OFS_CTRL: begin
          nxt_regs.rdata = {28'h0, regs_ff.ctrl};
        end
        OFS_IRQ_STAT: begin
          nxt_regs.rdata = {26'h0, regs_ff.irq_stat};
        end
        OFS_IRQ_MASK: begin
          nxt_regs.rdata = {26'h0, regs_ff.irq_mask};
        end
        default: begin
          nxt_regs.rdata = 32'h0000_0000;
        end
      endcase
    end

    // sticky events
    // read clears, but a new edge in the same cycle wins
    if (RD_IN && ADDR_IN == OFS_IRQ_STAT) begin
      nxt_regs.irq_stat = '0;
    end
    nxt_regs.irq_stat = nxt_regs.irq_stat | (flg_now & ~regs_ff.flags);

    case (regs_ff.state)
      AFD_IDLE: begin
        if (regs_ff.ctrl[BIT_GO] && mode != MODE_CPU_CPU) begin
          nxt_regs.state  = AFD_WAIT;
          nxt_regs.idx    = '0;
          nxt_regs.mism   = 1'b0;
          nxt_regs.pass_n = 1'b1;
          nxt_regs.fail_n = 1'b1;
        end
      end
      AFD_WAIT: begin
        if (mode == MODE_CPU_FAB && full) begin
          nxt_regs.state = AFD_MOVE;
        end else if (mode == MODE_FAB_CPU) begin
          nxt_regs.state = AFD_MOVE;
        end
      end
      AFD_MOVE: begin
        if (mode == MODE_FAB_CPU) begin
          if (push_ok) begin
            nxt_regs.idx = regs_ff.idx + 1'b1;
          end
          if (full) begin
            nxt_regs.state = AFD_DONE;
          end
        end else begin
          if (pop_ok) begin
            nxt_regs.idx = regs_ff.idx + 1'b1;
            if (head != afd_pattern(regs_ff.idx)) begin
              nxt_regs.mism   = 1'b1;
              nxt_regs.fail_n = 1'b0;
            end
          end
          if (pop_ok && regs_ff.count == (AW+1)'(1)) begin
            nxt_regs.state = AFD_DONE;
            nxt_regs.pass_n = regs_ff.mism ||
                              (head != afd_pattern(regs_ff.idx));
          end
        end
      end
      AFD_DONE: begin
        if (regs_ff.ctrl[BIT_GO]) begin
          nxt_regs.state = AFD_IDLE;
        end
      end
      default: begin
        nxt_regs.state = AFD_IDLE;
      end
    endcase

    nxt_regs.gpio_e = empty;
    nxt_regs.gpio_f = full;
  end

  // ************************************************************
  // state register
  // ************************************************************
  // single fabric clock domain
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      regs_ff          <= '0;
      regs_ff.ctrl     <= CTRL_RST;
      regs_ff.irq_mask <= IRQ_MASK_RST;
      regs_ff.flags    <= 6'h02;
      regs_ff.state    <= AFD_IDLE;
      regs_ff.pass_n   <= 1'b1;
      regs_ff.fail_n   <= 1'b1;
      regs_ff.gpio_e   <= 1'b1;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign RDATA_OUT      = regs_ff.rdata;
  assign IRQ_OUT        = |(regs_ff.irq_stat & regs_ff.irq_mask);
  assign GPIO_EMPTY_OUT = regs_ff.gpio_e;
  assign GPIO_FULL_OUT  = regs_ff.gpio_f;
  assign RD_PASS_N_OUT  = regs_ff.pass_n;
  assign RD_FAIL_N_OUT  = regs_ff.fail_n;

endmodule : afd_top

// file: core/afd_pkg.sv
package afd_pkg;

  // ************************************************************
  // clocking
  // ************************************************************
  localparam longint CLK_SYS_HZ   = 250_000_000;
  localparam int     CLK_FAB_MHZ  = 50;
  localparam int     CLK_CPU_MHZ  = 200;
  localparam int     CLK_BRD_MHZ  = 20;

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam int          REG_AW       = 5;
  localparam logic [4:0]  OFS_DATA     = 5'h00;
  localparam logic [4:0]  OFS_STAT_W   = 5'h04;
  localparam logic [4:0]  OFS_STAT_R   = 5'h08;
  localparam logic [4:0]  OFS_WRCNT    = 5'h0C;
  localparam logic [4:0]  OFS_RDCNT    = 5'h10;
  localparam logic [4:0]  OFS_CTRL     = 5'h14;
  localparam logic [4:0]  OFS_IRQ_STAT = 5'h18;
  localparam logic [4:0]  OFS_IRQ_MASK = 5'h1C;

  // ************************************************************
  // flag bit positions (status, irq status, irq mask)
  // ************************************************************
  localparam int FLG_W        = 6;
  localparam int BIT_FULL     = 0;
  localparam int BIT_EMPTY    = 1;
  localparam int BIT_AFULL    = 2;
  localparam int BIT_AEMPTY   = 3;
  localparam int BIT_PFULL    = 4;
  localparam int BIT_PEMPTY   = 5;
  localparam logic [5:0] WR_SIDE_BITS = 6'h15;
  localparam logic [5:0] RD_SIDE_BITS = 6'h2A;

  // ************************************************************
  // control fields
  // ************************************************************
  localparam int BIT_MODE_LO  = 0;
  localparam int BIT_FIRST_WORD_FALL_THROUGH     = 2;
  localparam int BIT_GO       = 3;
  localparam logic [1:0] MODE_CPU_CPU = 2'h0;
  localparam logic [1:0] MODE_CPU_FAB = 2'h1;
  localparam logic [1:0] MODE_FAB_CPU = 2'h2;
  localparam logic [3:0] CTRL_RST     = 4'h0;
  localparam logic [5:0] IRQ_MASK_RST = 6'h00;

  // ************************************************************
  // fifo geometry and thresholds
  // ************************************************************
  localparam int DEF_DEPTH     = 512;
  localparam int DEF_WIDTH     = 32;
  localparam int DEF_PFULL     = 'h1F0;
  localparam int DEF_PEMPTY    = 8;
  localparam logic [31:0] DEF_PAT_BASE = 32'hC000_0000;

  typedef enum logic [1:0] {
    AFD_IDLE  = 2'h0,
    AFD_WAIT  = 2'h1,
    AFD_MOVE  = 2'h3,
    AFD_DONE  = 2'h2
  } afd_state_t;

endpackage : afd_pkg

// file: dv/afd_top_asserts.sv
`timescale 1ns/1ps
module afd_top_asserts
  import afd_pkg::*;
(
  input wire logic              CLK_SYS_IN,
  input wire logic              RSTN_IN,
  input wire logic              PLL_LOCK_IN,
  input wire logic [REG_AW-1:0] ADDR_IN,
  input wire logic [31:0]       WDATA_IN,
  input wire logic              WR_IN,
  input wire logic              RD_IN,
  input wire logic [31:0]       RDATA_OUT,
  input wire logic              IRQ_OUT,
  input wire logic              GPIO_EMPTY_OUT,
  input wire logic              GPIO_FULL_OUT,
  input wire logic              RD_PASS_N_OUT,
  input wire logic              RD_FAIL_N_OUT
);
  // ********
  // checks
  // ********
  wire logic rst_act = !RSTN_IN || !PLL_LOCK_IN;
  default clocking dcb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (rst_act);
  rst_vals_a: assert property (disable iff (1'b0)
    rst_act ##1 rst_act |-> GPIO_EMPTY_OUT && !GPIO_FULL_OUT && !IRQ_OUT
    && RD_PASS_N_OUT && RD_FAIL_N_OUT && RDATA_OUT == '0)
    else $error("outputs not at reset values");
  gpio_excl_a: assert property (!(GPIO_FULL_OUT && GPIO_EMPTY_OUT))
    else $error("full and empty both shown");
  pass_fail_a: assert property (!(!RD_PASS_N_OUT && !RD_FAIL_N_OUT))
    else $error("pass and fail both low");
  fail_hold_a: assert property (!RD_FAIL_N_OUT |=> !RD_FAIL_N_OUT
    || $past(WR_IN, 2) || $past(WR_IN, 3))
    else $error("fail released without a go");
  pass_empty_a: assert property ($fell(RD_PASS_N_OUT) |-> ##[0:3]
    GPIO_EMPTY_OUT)
    else $error("pass shown before drain ends");
  stat_w_bits_a: assert property (RD_IN && ADDR_IN == OFS_STAT_W |=>
    (RDATA_OUT & ~32'(WR_SIDE_BITS)) == '0)
    else $error("write status has read bits");
  stat_r_bits_a: assert property (RD_IN && ADDR_IN == OFS_STAT_R |=>
    (RDATA_OUT & ~32'(RD_SIDE_BITS)) == '0)
    else $error("read status has write bits");
  cnt_wrap_a: assert property (RD_IN && (ADDR_IN == OFS_WRCNT
    || ADDR_IN == OFS_RDCNT) |=> RDATA_OUT[31:9] == '0)
    else $error("count beyond 511");
  irq_read_a: assert property (RD_IN && ADDR_IN == OFS_IRQ_STAT
    && IRQ_OUT |=> RDATA_OUT != '0)
    else $error("irq high with empty status");
  irq_fall_a: assert property ($fell(IRQ_OUT) |-> $past(WR_IN, 1)
    || $past(RD_IN, 1))
    else $error("irq dropped with no access");
  irq_mask_a: assert property (WR_IN && ADDR_IN == OFS_IRQ_MASK
    && WDATA_IN[5:0] == '0 |-> ##2 !IRQ_OUT)
    else $error("irq high with zero mask");
  cover property ($fell(RD_PASS_N_OUT));
  cover property ($fell(RD_FAIL_N_OUT));
  cover property ($rose(GPIO_FULL_OUT));
  cover property ($rose(IRQ_OUT));
endmodule : afd_top_asserts

bind afd_top afd_top_asserts u_asserts (
  .CLK_SYS_IN(CLK_SYS_IN), .RSTN_IN(RSTN_IN), .PLL_LOCK_IN(PLL_LOCK_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT), .GPIO_EMPTY_OUT(GPIO_EMPTY_OUT),
  .GPIO_FULL_OUT(GPIO_FULL_OUT), .RD_PASS_N_OUT(RD_PASS_N_OUT),
  .RD_FAIL_N_OUT(RD_FAIL_N_OUT)
);

// file: dv/afd_cpu_model.sv
`timescale 1ns/1ps
module afd_cpu_model
  import afd_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic [31:0]       rdata_in,
  input  wire logic              gpio_empty_in,
  output logic      [REG_AW-1:0] addr_out,
  output logic      [31:0]       wdata_out,
  output logic                   wr_out,
  output logic                   rd_out
);
  // ********
  // bus master
  // ********
  initial begin
    addr_out = '0;
    wdata_out = '0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // released lines show the inverse, never a stale copy
  task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge clk_in);
    addr_out <= ~a;
    wdata_out <= ~v;
    wr_out <= 1'b0;
  endtask : wr
  task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    addr_out <= ~a;
    rd_out <= 1'b0;
    #1;
    v = rdata_in;
  endtask : rd
  task automatic wait_empty();
    for (int k = 0; k < 1000 && gpio_empty_in !== 1'b1; k++)
      @(posedge clk_in);
  endtask : wait_empty
endmodule : afd_cpu_model

// file: dv/afd_top_tb.sv
`timescale 1ns/1ps
module afd_top_tb
  import afd_pkg::*;
;
  localparam int N = DEF_DEPTH;
  logic        clk;
  logic        rstn;
  logic        lock;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        irq;
  logic        g_emp;
  logic        g_full;
  logic        pass_n;
  logic        fail_n;
  logic [31:0] d;
  logic [31:0] mem [N];
  int          num_errors = 0;
  int          compares = 0;
  // ********
  // harness
  // ********
  afd_top DUT (
    .CLK_SYS_IN(clk), .RSTN_IN(rstn), .PLL_LOCK_IN(lock), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .IRQ_OUT(irq), .GPIO_EMPTY_OUT(g_emp), .GPIO_FULL_OUT(g_full),
    .RD_PASS_N_OUT(pass_n), .RD_FAIL_N_OUT(fail_n)
  );
  afd_cpu_model cpu (
    .clk_in(clk), .rdata_in(rdata), .gpio_empty_in(g_emp),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] exp_sw(input int n);
    exp_sw = '0;
    exp_sw[BIT_PFULL] = (n >= DEF_PFULL);
    exp_sw[BIT_AFULL] = (n == N - 1);
    exp_sw[BIT_FULL] = (n == N);
  endfunction : exp_sw
  function automatic logic [31:0] exp_sr(input int n);
    exp_sr = '0;
    exp_sr[BIT_PEMPTY] = (n <= DEF_PEMPTY);
    exp_sr[BIT_AEMPTY] = (n == 1);
    exp_sr[BIT_EMPTY] = (n == 0);
  endfunction : exp_sr
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, e);
    end
  endtask : chk
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    cpu.rd(a, d);
    chk(d, e);
  endtask : rchk
  task automatic fill(input int bad, input bit st);
    for (int i = 0; i < N; i++) begin
      cpu.wr(OFS_DATA, mem[i] ^ 32'(i == bad));
      if (st) begin
        rchk(OFS_STAT_W, exp_sw(i + 1));
        rchk(OFS_WRCNT, 32'((i + 1) % N));
      end
    end
  endtask : fill
  task automatic drain();
    for (int i = N - 1; i >= 0; i--) begin
      rchk(OFS_DATA, mem[N - 1 - i]);
      rchk(OFS_STAT_R, exp_sr(i));
      rchk(OFS_RDCNT, 32'(i));
    end
  endtask : drain
  task automatic wait_pf(input logic [1:0] e);
    for (int k = 0; k < 2000; k++) begin
      if (g_emp === 1'b1 && {pass_n, fail_n} === e) break;
      @(posedge clk);
    end
    chk(32'({pass_n, fail_n}), 32'(e));
  endtask : wait_pf
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // about six times the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    rstn = 1'b0;
    lock = 1'b0;
    void'($urandom(32'h8A57));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    lock <= 1'b1;
    repeat (3) @(posedge clk);
    chk({27'h0, g_emp, g_full, pass_n, fail_n, irq}, 32'h16);
    rchk(OFS_CTRL, 32'(CTRL_RST));
    rchk(OFS_IRQ_MASK, 32'(IRQ_MASK_RST));
    for (int i = 0; i < 5; i++) cpu.wr(OFS_DATA, 32'h5);
    lock <= 1'b0;
    repeat (2) @(posedge clk);
    lock <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(OFS_WRCNT, 32'h0);
    cpu.rd(OFS_IRQ_STAT, d);
    foreach (mem[i]) mem[i] = $urandom();
    cpu.wr(OFS_IRQ_MASK, 32'(WR_SIDE_BITS));
    fill(N, 1'b1);
    chk(32'(irq), 32'h1);
    cpu.wr(OFS_IRQ_MASK, 32'h0);
    rchk(OFS_IRQ_MASK, 32'h0);
    chk(32'(irq), 32'h0);
    cpu.wr(OFS_IRQ_MASK, 32'(WR_SIDE_BITS));
    rchk(OFS_IRQ_MASK, 32'(WR_SIDE_BITS));
    chk(32'(irq), 32'h1);
    rchk(OFS_IRQ_STAT, 32'h1D);
    chk(32'(irq), 32'h0);
    cpu.wr(OFS_DATA, 32'h0);
    rchk(OFS_WRCNT, 32'h0);
    rchk(OFS_STAT_W, 32'h11);
    cpu.wr(OFS_IRQ_MASK, 32'(RD_SIDE_BITS));
    drain();
    chk(32'(irq), 32'h1);
    rchk(OFS_IRQ_STAT, 32'h2E);
    rchk(OFS_DATA, 32'h0);
    rchk(OFS_RDCNT, 32'h0);
    foreach (mem[i]) mem[i] = DEF_PAT_BASE + 32'(4 * i);
    cpu.wr(OFS_CTRL, 32'h9);
    cpu.wait_empty();
    chk(32'(g_emp), 32'h1);
    fill(N, 1'b0);
    wait_pf(2'b01);
    cpu.wr(OFS_CTRL, 32'h9);
    cpu.wr(OFS_CTRL, 32'h9);
    repeat (4) @(posedge clk);
    chk(32'({pass_n, fail_n}), 32'h3);
    fill(int'($urandom_range(N - 1)), 1'b0);
    wait_pf(2'b10);
    cpu.wr(OFS_CTRL, 32'hA);
    cpu.wr(OFS_CTRL, 32'hA);
    for (int k = 0; k < 1000 && g_full !== 1'b1; k++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk(32'(g_full), 32'h1);
    rchk(OFS_WRCNT, 32'h0);
    drain();
    summarize();
  end
endmodule : afd_top_tb
